// File: verilog/hub_port_disable_power_cfg.sv
// Overview of operation
// - set bit disables port, clear keeps it
// - applies only bus-powered with renumbering off
// - report enabled count, keep ports contiguous
// - default configuration uses strap pins instead
// - bit2 port2, bit1 port1, rest reserved
// - port-disable register RW, resets to zero
// - self-powered budget 8-bit RW, 2mA units
// - bus-powered budget 8-bit RW, 2mA units
// - renumber bit selects standard or remap mode
`timescale 1ns/1ps
module hub_port_disable_power_cfg (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire hub_cfg_pkg::reg_req_s req_i,
	output logic [7:0] rdata_o,
	input wire logic [1:0] port_off_strap_pins_i,
	output logic [1:0] port_enabled_o,
	output logic [1:0] enabled_port_count_o,
	output logic [1:0] logical_port1_phys_o,
	output logic [1:0] logical_port2_phys_o,
	output logic remap_active_o,
	output logic [7:0] self_power_current_budget_o,
	output logic [7:0] bus_power_current_budget_o
);
	import hub_cfg_pkg::*;

	// software registers
	logic [7:0] bus_power_port_off_mask; // disable mask, reserved kept zero
	logic [7:0] self_power_current_budget; // 2 mA units
	logic [7:0] bus_power_current_budget; // 2 mA units
	logic [7:0] hub_mode; // renumber, bus-powered, default-config bits
	logic [7:0] rdata;
	logic [7:0] next_mask;
	logic [7:0] next_sp;
	logic [7:0] next_bp;
	logic [7:0] next_mode;
	logic [7:0] next_rdata;
	// strap synchroniser, first stage read only by second
	logic [1:0] strap_meta;
	logic [1:0] strap_sync;
	// derived port layout, registered
	logic [1:0] port_en;
	logic [1:0] port_cnt;
	logic [1:0] lp1;
	logic [1:0] lp2;
	logic next_remap;
	logic remap_q;
	logic [1:0] disable_sel;
	logic [1:0] next_en;
	logic [1:0] next_cnt;
	logic [1:0] next_lp1;
	logic [1:0] next_lp2;

	// register next values; writes mask reserved bits off
	always_comb begin
		next_mask = bus_power_port_off_mask;
		next_sp = self_power_current_budget;
		next_bp = bus_power_current_budget;
		next_mode = hub_mode;
		next_rdata = UNMAPPED_READ;
		if (req_i.wr) begin
			unique case (req_i.addr)
				OFS_PORT_DISABLE_BP: begin
					next_mask = req_i.wdata & PORT_DIS_IMPL_MASK;
				end
				OFS_MAX_POWER_SP: begin
					next_sp = req_i.wdata;
				end
				OFS_MAX_POWER_BP: begin
					next_bp = req_i.wdata;
				end
				OFS_HUB_MODE: begin
					// unused mode bits are dropped so they read zero
					next_mode = req_i.wdata & HUB_MODE_IMPL_MASK;
				end
				default: begin
					// unmapped writes are dropped
				end
			endcase
		end
		if (req_i.rd) begin
			unique case (req_i.addr)
				OFS_PORT_DISABLE_BP: begin
					next_rdata = bus_power_port_off_mask;
				end
				OFS_MAX_POWER_SP: begin
					next_rdata = self_power_current_budget;
				end
				OFS_MAX_POWER_BP: begin
					next_rdata = bus_power_current_budget;
				end
				OFS_HUB_MODE: begin
					next_rdata = hub_mode;
				end
				OFS_PORT_STATUS: begin
					// state readback: count in [5:4], enables in [2:1]
					next_rdata = {2'h0, port_cnt, 1'h0, port_en, 1'h0};
				end
				default: begin
					next_rdata = UNMAPPED_READ;
				end
			endcase
		end
	end

	// register stage; read data stands for one cycle only
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			bus_power_port_off_mask <= RST_PORT_DISABLE_BP;
			self_power_current_budget <= RST_MAX_POWER_SP;
			bus_power_current_budget <= RST_MAX_POWER_BP;
			hub_mode <= RST_HUB_MODE;
			rdata <= 8'h00;
		end else begin
			bus_power_port_off_mask <= next_mask;
			self_power_current_budget <= next_sp;
			bus_power_current_budget <= next_bp;
			hub_mode <= next_mode;
			rdata <= next_rdata;
		end
	end

	// two flops on the strap pins, which come from outside
	// limitation: straps are followed all the time, not latched at reset
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			strap_meta <= 2'h0;
			strap_sync <= 2'h0;
		end else begin
			strap_meta <= port_off_strap_pins_i;
			strap_sync <= strap_meta;
		end
	end

	// port layout: which source disables ports, then renumbering
	always_comb begin
		next_remap = hub_mode[MODE_RENUMBER_BIT];
		disable_sel = 2'h0;
		// default configuration outranks the mode and mask bits
		if (hub_mode[MODE_DEFAULT_CFG_BIT]) begin
			disable_sel = strap_sync;
		end else if (!next_remap && hub_mode[MODE_BUS_POWERED_BIT]) begin
			disable_sel = {bus_power_port_off_mask[PORT2_BIT],
				bus_power_port_off_mask[PORT1_BIT]};
		end
		// remap mode uses its own table, not modelled: all ports stay up unless default configuration applies the straps
		next_en = ~disable_sel;
		next_cnt = 2'(next_en[0]) + 2'(next_en[1]);
		// logical port n maps to the n-th enabled physical port; 0 = none
		next_lp1 = 2'h0;
		next_lp2 = 2'h0;
		if (next_en[0]) begin
			next_lp1 = 2'h1;
			if (next_en[1]) begin
				next_lp2 = 2'h2;
			end
		end else if (next_en[1]) begin
			next_lp1 = 2'h2;
		end
	end

	// layout registered so outputs come from flops
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			port_en <= 2'h3;
			port_cnt <= 2'h2;
			lp1 <= 2'h1;
			lp2 <= 2'h2;
			remap_q <= 1'b0;
		end else begin
			port_en <= next_en;
			port_cnt <= next_cnt;
			lp1 <= next_lp1;
			lp2 <= next_lp2;
			remap_q <= next_remap;
		end
	end

	assign rdata_o = rdata;
	assign port_enabled_o = port_en;
	assign enabled_port_count_o = port_cnt;
	assign logical_port1_phys_o = lp1;
	assign logical_port2_phys_o = lp2;
	assign remap_active_o = remap_q;
	// budgets exported as stored; limits are software's job
	assign self_power_current_budget_o = self_power_current_budget;
	assign bus_power_current_budget_o = bus_power_current_budget;

	// checks
	AST_RESERVED_ZERO: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		(bus_power_port_off_mask & ~PORT_DIS_IMPL_MASK) == 8'h00)
		else $error("reserved disable bits set");
	AST_MASK_WRITE: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		req_i.wr && req_i.addr == OFS_PORT_DISABLE_BP |=>
		bus_power_port_off_mask == ($past(req_i.wdata) & PORT_DIS_IMPL_MASK))
		else $error("disable register write lost");
	AST_SP_READ: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		req_i.rd && req_i.addr == OFS_MAX_POWER_SP && !req_i.wr |=>
		rdata_o == $past(self_power_current_budget))
		else $error("self budget readback wrong");
	AST_BP_WRITE: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		req_i.wr && req_i.addr == OFS_MAX_POWER_BP |=>
		bus_power_current_budget_o == $past(req_i.wdata))
		else $error("bus budget write lost");
	AST_BP_DISABLE: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		!hub_mode[MODE_DEFAULT_CFG_BIT] && hub_mode[MODE_BUS_POWERED_BIT]
		&& !hub_mode[MODE_RENUMBER_BIT] && bus_power_port_off_mask[PORT2_BIT]
		|=> !port_enabled_o[1])
		else $error("port 2 not disabled");
	AST_NO_EFFECT: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		!hub_mode[MODE_DEFAULT_CFG_BIT] && (hub_mode[MODE_RENUMBER_BIT]
		|| !hub_mode[MODE_BUS_POWERED_BIT]) |=> port_enabled_o == 2'h3)
		else $error("mask applied outside bus-powered mode");
	AST_STRAP: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		hub_mode[MODE_DEFAULT_CFG_BIT] |=> port_enabled_o == ~$past(strap_sync))
		else $error("straps not followed");
	AST_COUNT: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		enabled_port_count_o == 2'(port_enabled_o[0]) + 2'(port_enabled_o[1]))
		else $error("enabled count mismatch");
	AST_CONTIG: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		port_enabled_o == 2'h2 |-> logical_port1_phys_o == 2'h2
		&& logical_port2_phys_o == 2'h0)
		else $error("ports not renumbered");
	AST_ENABLE_BIT: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		!hub_mode[MODE_DEFAULT_CFG_BIT] && hub_mode[MODE_BUS_POWERED_BIT]
		&& !hub_mode[MODE_RENUMBER_BIT] && !bus_power_port_off_mask[PORT1_BIT]
		|=> port_enabled_o[0])
		else $error("port 1 wrongly disabled");

	// further checks on the registers and the port layout
	// reset puts the disable mask, both budgets and the read data back to their defaults
	AST_RESET_VALUES: assert property (@(posedge sys_clk_i)
		!rst_n_i |=> bus_power_port_off_mask == RST_PORT_DISABLE_BP
		&& self_power_current_budget == RST_MAX_POWER_SP
		&& bus_power_current_budget == RST_MAX_POWER_BP
		&& rdata_o == 8'h00)
		else $error("register not back at reset value");
	// budget writes land in the cycle after the strobe
	AST_SP_WRITE: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		req_i.wr && req_i.addr == OFS_MAX_POWER_SP |=>
		self_power_current_budget_o == $past(req_i.wdata))
		else $error("self budget write lost");
	// read answers carry the value that stood when the strobe came
	AST_BP_READ: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		req_i.rd && req_i.addr == OFS_MAX_POWER_BP && !req_i.wr |=>
		rdata_o == $past(bus_power_current_budget))
		else $error("bus budget readback wrong");
	// reserved disable bits never come back set on a read
	AST_MASK_READ: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		req_i.rd && req_i.addr == OFS_PORT_DISABLE_BP && !req_i.wr |=>
		rdata_o == $past(bus_power_port_off_mask)
		&& (rdata_o & ~PORT_DIS_IMPL_MASK) == 8'h00)
		else $error("disable register readback wrong");
	// bit 1 of the mask takes physical port 1 away
	AST_PORT1_OFF: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		!hub_mode[MODE_DEFAULT_CFG_BIT] && hub_mode[MODE_BUS_POWERED_BIT]
		&& !hub_mode[MODE_RENUMBER_BIT] && bus_power_port_off_mask[PORT1_BIT]
		|=> !port_enabled_o[0])
		else $error("port 1 not disabled");
	// a clear bit 2 leaves physical port 2 available
	AST_PORT2_ON: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		!hub_mode[MODE_DEFAULT_CFG_BIT] && hub_mode[MODE_BUS_POWERED_BIT]
		&& !hub_mode[MODE_RENUMBER_BIT] && !bus_power_port_off_mask[PORT2_BIT]
		|=> port_enabled_o[1])
		else $error("port 2 wrongly disabled");
	// with both ports up the host sees them in physical order
	AST_LAYOUT_FULL: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		port_enabled_o == 2'h3 |-> logical_port1_phys_o == 2'h1
		&& logical_port2_phys_o == 2'h2)
		else $error("full layout misnumbered");
	// a second logical port exists only when both are up
	AST_LAYOUT_SHORT: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		port_enabled_o != 2'h3 |-> logical_port2_phys_o == 2'h0
		&& logical_port1_phys_o == (port_enabled_o[0] ? 2'h1 :
		{port_enabled_o[1], 1'b0}))
		else $error("missing port still reported");
	// the renumber flag follows the mode bit one cycle later
	AST_REMAP_FLAG: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		1'b1 |=> remap_active_o == $past(hub_mode[MODE_RENUMBER_BIT]))
		else $error("renumber flag out of step");
	// straps reach the layout logic two cycles after the pins
	AST_STRAP_SYNC: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i)
		$past(rst_n_i) |=> strap_sync == $past(port_off_strap_pins_i, 2))
		else $error("strap synchroniser out of step");
endmodule : hub_port_disable_power_cfg

// File: include/hub_cfg_pkg.sv
package hub_cfg_pkg;
	// register offsets (byte addresses on the plain port)
	localparam logic [7:0] OFS_PORT_DISABLE_BP = 8'h0B;
	localparam logic [7:0] OFS_MAX_POWER_SP = 8'h0C;
	localparam logic [7:0] OFS_MAX_POWER_BP = 8'h0D;
	// control register holding the operating-mode bits
	localparam logic [7:0] OFS_HUB_MODE = 8'h08;
	// read-only status of the resulting port layout
	localparam logic [7:0] OFS_PORT_STATUS = 8'h40;
	// reset values
	localparam logic [7:0] RST_PORT_DISABLE_BP = 8'h00;
	localparam logic [7:0] RST_MAX_POWER_SP = 8'h00;
	localparam logic [7:0] RST_MAX_POWER_BP = 8'h00;
	localparam logic [7:0] RST_HUB_MODE = 8'h00;
	// implemented bits of the port-disable field
	localparam logic [7:0] PORT_DIS_IMPL_MASK = 8'h06;
	localparam int PORT1_BIT = 1;
	localparam int PORT2_BIT = 2;
	// mode register fields
	localparam int MODE_RENUMBER_BIT = 3;
	localparam int MODE_BUS_POWERED_BIT = 1;
	localparam int MODE_DEFAULT_CFG_BIT = 0;
	localparam logic [7:0] HUB_MODE_IMPL_MASK = 8'h0B;
	localparam int NUM_PORTS = 2;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// register port request carrier
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;
endpackage : hub_cfg_pkg

// File: sim/hub_port_disable_power_cfg_tb_top.sv
`timescale 1ns/1ps
module hub_port_disable_power_cfg_tb_top;
	import hub_cfg_pkg::*;
	logic sys_clk_i = 1'b0; // 25 MHz bench clock
	logic rst_n_i = 1'b0; // held low for the first 10 edges
	reg_req_s req = '0; // register port request
	logic [7:0] rdata_o;
	logic [1:0] straps = 2'h0; // port-off strap pins
	logic [1:0] en, cnt, lp1, lp2;
	logic remap;
	logic [7:0] sp_bud, bp_bud;
	logic rd_taken = 1'b0; // a read answer is due this cycle
	logic [7:0] exp_q[$]; // expected read data, oldest first
	int fail_count = 0;
	int n_compared = 0;
	logic [7:0] v1, v2;

	always #20 sys_clk_i = ~sys_clk_i;

	hub_port_disable_power_cfg i_hub_port_disable_power_cfg (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req),
		.rdata_o(rdata_o), .port_off_strap_pins_i(straps),
		.port_enabled_o(en), .enabled_port_count_o(cnt),
		.logical_port1_phys_o(lp1), .logical_port2_phys_o(lp2),
		.remap_active_o(remap), .self_power_current_budget_o(sp_bud),
		.bus_power_current_budget_o(bp_bud));

	// single place where the run ends
	task end_sim;
		if (fail_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim

	task cmp8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask : cmp8

	// one-cycle write strobe, released on the next edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk_i);
		req.wr <= 1'b0;
	endtask : wr

	// read strobe; the monitor checks the answer a cycle later
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk_i);
		exp_q.push_back(exp);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk_i);
		req.rd <= 1'b0;
	endtask : rd

	// expected numbering keeps the live ports contiguous from 1
	task cmp_layout(input logic [1:0] e, input logic rm);
		logic [1:0] x1;
		logic [1:0] x2;
		logic [1:0] ec;
		x1 = e[0] ? 2'h1 : (e[1] ? 2'h2 : 2'h0);
		x2 = (e == 2'h3) ? 2'h2 : 2'h0;
		ec = 2'(e[0]) + 2'(e[1]);
		// straps need three edges to land, so four is safe
		repeat (4) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		n_compared++;
		if ({en, cnt, lp1, lp2, remap} !== {e, ec, x1, x2, rm}) begin
			fail_count++;
			$display("[FAIL] %0t port layout wrong, expected enables %b",
				$time, e);
		end
		// the status word must tell the same story
		rd(OFS_PORT_STATUS, {2'h0, ec, 1'h0, e, 1'h0});
	endtask : cmp_layout

	// read answers stand one cycle only, zero otherwise
	always @(posedge sys_clk_i) rd_taken <= req.rd;
	always @(negedge sys_clk_i) begin
		if (rd_taken) begin
			if (exp_q.size() == 0) begin
				fail_count++;
				$display("[FAIL] %0t unexpected read answer", $time);
			end else begin
				cmp8(rdata_o, exp_q.pop_front());
			end
		end else if (rst_n_i) begin
			cmp8(rdata_o, 8'h00);
		end
	end

	// watchdog cuts a hang short
	initial begin
		repeat (3000) @(posedge sys_clk_i);
		fail_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_sim();
	end

	initial begin
		void'($urandom(32'h4bdd));
		repeat (10) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		cmp_layout(2'h3, 1'b0);
		rd(OFS_PORT_DISABLE_BP, RST_PORT_DISABLE_BP);
		rd(OFS_MAX_POWER_SP, RST_MAX_POWER_SP);
		rd(OFS_MAX_POWER_BP, RST_MAX_POWER_BP);
		rd(OFS_HUB_MODE, RST_HUB_MODE);
		// self budget kept inside the 100 mA limit, 50 steps of 2 mA
		v1 = 8'($urandom % 51);
		// bus budget: hub figure plus an embedded peripheral's current
		v2 = 8'($urandom % 100) + 8'($urandom % 100);
		wr(OFS_MAX_POWER_SP, v1);
		wr(OFS_MAX_POWER_BP, v2);
		wr(8'h20, 8'hFF);
		rd(8'h20, UNMAPPED_READ);
		rd(OFS_MAX_POWER_SP, v1);
		rd(OFS_MAX_POWER_BP, v2);
		@(negedge sys_clk_i);
		cmp8(sp_bud, v1);
		cmp8(bp_bud, v2);
		// bus-powered, standard numbering: every mask, junk in reserved bits
		wr(OFS_HUB_MODE, 8'h02);
		for (int m = 0; m < 4; m++) begin
			v1 = 8'($urandom) & ~PORT_DIS_IMPL_MASK | 8'(m << 1);
			wr(OFS_PORT_DISABLE_BP, v1);
			rd(OFS_PORT_DISABLE_BP, 8'(m << 1));
			cmp_layout(~2'(m), 1'b0);
		end
		// mask stays at both-off; other modes must ignore it
		wr(OFS_HUB_MODE, 8'h00);
		cmp_layout(2'h3, 1'b0);
		wr(OFS_HUB_MODE, 8'h0A);
		rd(OFS_HUB_MODE, 8'h0A);
		cmp_layout(2'h3, 1'b1);
		// default configuration: straps decide
		wr(OFS_HUB_MODE, 8'h03);
		for (int s = 0; s < 4; s++) begin
			@(posedge sys_clk_i);
			straps <= 2'(s);
			cmp_layout(~2'(s), 1'b0);
		end
		// mid-run reset must bring the disable mask and both budgets back to zero
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		rd(OFS_PORT_DISABLE_BP, RST_PORT_DISABLE_BP);
		rd(OFS_MAX_POWER_SP, RST_MAX_POWER_SP);
		rd(OFS_MAX_POWER_BP, RST_MAX_POWER_BP);
		cmp_layout(2'h3, 1'b0);
		repeat (3) @(posedge sys_clk_i);
		end_sim();
	end
endmodule : hub_port_disable_power_cfg_tb_top
